/* aort_pkg.sv */
// Purpose: constants for the over-range and mark-bit sample post-processor
// Assumes: one sampling clock, AHB-Lite register access
// Notes:   byte offsets below are word aligned
package aort_pkg;
    localparam int          SAMPLE_W        = 12;
    localparam int          NUM_CH          = 4;
    localparam int          MAG_TOP_W       = 8;
    localparam int          HOLD_SEL_W      = 3;
    localparam int          HOLD_BASE_LOG2  = 3;
    localparam int          HOLD_CNT_W      = 11;
    localparam logic [11:0] SAMPLE_MOST_NEG = 12'h800;
    localparam logic [10:0] MAG_SAT         = 11'h7FF;
    localparam logic [1:0]  ECHO_SEL_MARK   = 2'h3;

    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_THRESH   = 8'h04;
    localparam logic [7:0]  OFS_STATUS   = 8'h08;
    localparam logic [7:0]  OFS_IRQ_STAT = 8'h0C;
    localparam logic [7:0]  OFS_IRQ_MASK = 8'h10;

    localparam int          CTRL_DET_EN   = 0;
    localparam int          CTRL_HOLD_LSB = 1;
    localparam int          CTRL_ECHO_EN  = 4;
    localparam int          CTRL_ECHO_LSB = 5;
    localparam int          CTRL_RECV_EN  = 7;
    localparam int          CTRL_INS_EN   = 8;
    localparam logic [7:0]  THRESH_RESET  = 8'hE4;
    localparam int          IRQ_OVR_LSB   = 0;
    localparam int          IRQ_MARK      = 4;
endpackage

/* aort_core.sv */
// Purpose: signed sample coding, over-range flags, mark bit echo and insertion
// Assumes: samples arrive in the sampling clock domain; mark input is asynchronous
// Notes:   registers over AHB-Lite, zero wait states, OKAY always
// Operation
// - capture each sample on rising edge as signed two's complement code
// - take absolute value, compare upper 8 magnitude bits with threshold
// - one threshold shared by all four channels
// - most negative code saturates to magnitude 2047, compare value 255
// - detector produces flags only while its enable is set
// - flag set when upper magnitude bits are at or above threshold
// - four separate flag outputs, one for each channel
// - 3-bit hold select gives 8 to 1024 cycle pulses
// - each new over-range event restarts the hold interval
// - retimed mark repeated on echo pair when enabled and select equals 3
// - mark bit goes into link data only while insertion enable is set
// - mark replaces sample bit 0, sample upper 11 bits occupy [11:1]
// - mark sampled like a 1-bit converter with matched latency; here it reaches link data four register stages after the samples
// - foreground calibration halts sampling, background keeps sampling
// - six cores are swapped so one calibrates while others convert
`default_nettype none
module aort_core
    import aort_pkg::*;
(
    input  wire logic                clk_sys_i,
    input  wire logic                rst_i,
    input  wire logic [NUM_CH*SAMPLE_W-1:0] sample_in_i,
    input  wire logic                sample_valid_i,
    input  wire logic                cal_foreground_i,
    input  wire logic                mark_input_pair_i,
    output logic [NUM_CH*SAMPLE_W-1:0] link_sample_o,
    output logic                     link_valid_o,
    output logic                     over_range_out_a_o,
    output logic                     over_range_out_b_o,
    output logic                     over_range_out_c_o,
    output logic                     over_range_out_d_o,
    output logic                     trigger_echo_pair_o,
    output logic                     irq_o,
    input  wire logic                hsel_i,
    input  wire logic [7:0]          haddr_i,
    input  wire logic [1:0]          htrans_i,
    input  wire logic                hwrite_i,
    input  wire logic [2:0]          hsize_i,
    input  wire logic [31:0]         hwdata_i,
    input  wire logic                hready_i,
    output logic [31:0]              hrdata_o,
    output logic                     hreadyout_o,
    output logic                     hresp_o
);
    // software-visible registers
    logic [8:0]           ctrl_r;
    logic [7:0]           overrange_threshold_r;
    logic [4:0]           irq_stat_r;
    logic [4:0]           irq_mask_r;

    // bus data-phase state
    logic                 wr_pend_r;
    logic [7:0]           wr_addr_r;
    logic                 addr_ok;
    logic                 rd_req;
    logic                 wr_req;
    logic                 wr_ctrl;
    logic                 wr_thresh;
    logic                 wr_mask;
    logic                 wr_clear;
    logic [4:0]           clear_mask;
    logic [4:0]           status_word;

    // mark path
    logic [2:0]           mark_sync_r;
    logic                 mark_agree;
    logic                 mark_lvl_r;
    logic                 mark_prev_r;
    logic                 mark_rise;
    logic                 echo_sel_ok;

    // sample and over-range path
    logic [SAMPLE_W-1:0]  chan_smp [NUM_CH];
    logic [MAG_TOP_W-1:0] chan_mag [NUM_CH];
    logic [NUM_CH-1:0]    flag_r;
    logic [HOLD_CNT_W-1:0] hold_cnt_r [NUM_CH];
    logic [NUM_CH-1:0]    hit;
    logic                 take;
    logic [4:0]           irq_set;
    logic [HOLD_CNT_W-1:0] hold_len;

    // decoded control fields
    logic                 overrange_detect_enable;
    logic [2:0]           overrange_hold_select;
    logic                 trigger_echo_enable;
    logic [1:0]           trigger_echo_select;
    logic                 mark_receiver_enable;
    logic                 mark_insert_enable;

    assign overrange_detect_enable = ctrl_r[CTRL_DET_EN];
    assign overrange_hold_select   = ctrl_r[CTRL_HOLD_LSB +: HOLD_SEL_W];
    assign trigger_echo_enable     = ctrl_r[CTRL_ECHO_EN];
    assign trigger_echo_select     = ctrl_r[CTRL_ECHO_LSB +: 2];
    assign mark_receiver_enable    = ctrl_r[CTRL_RECV_EN];
    assign mark_insert_enable      = ctrl_r[CTRL_INS_EN];

    // saturating magnitude, upper bits only
    function automatic logic [7:0] mag_top(input logic [11:0] s);
        logic [10:0] m;
        m = 11'h000;
        if (s == SAMPLE_MOST_NEG) begin
            m = MAG_SAT;
        end else if (s[11]) begin
            m = 11'((~s) + 12'h001);
        end else begin
            m = s[10:0];
        end
        return m[10:3];
    endfunction

    // 8 << select, an 11-bit cycle count so 1024 still fits
    function automatic logic [HOLD_CNT_W-1:0] hold_cycles(input logic [HOLD_SEL_W-1:0] sel);
        return HOLD_CNT_W'(11'h001 << (HOLD_BASE_LOG2 + int'(sel)));
    endfunction

    // the mark takes bit 0 and the sample keeps only its upper 11 bits
    function automatic logic [SAMPLE_W-1:0] insert_mark(input logic [SAMPLE_W-1:0] s,
                                                       input logic                m);
        return {s[SAMPLE_W-1:1], m};
    endfunction

    // counter step: reload on a hit, count down to zero, clear when off
    function automatic logic [HOLD_CNT_W-1:0] next_count(
        input logic                  en,
        input logic                  hit_c,
        input logic [HOLD_CNT_W-1:0] cnt,
        input logic [HOLD_CNT_W-1:0] len
    );
        logic [HOLD_CNT_W-1:0] n;
        n = cnt;
        if (!en) begin
            n = '0;
        end else if (hit_c) begin
            n = len - HOLD_CNT_W'(1);
        end else if (cnt != '0) begin
            n = cnt - HOLD_CNT_W'(1);
        end
        return n;
    endfunction

    // read mux; unmapped offsets read zero rather than alias a register
    function automatic logic [31:0] read_word(input logic [7:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (a)
            OFS_CTRL:     w = {23'h000000, ctrl_r};
            OFS_THRESH:   w = {24'h000000, overrange_threshold_r};
            OFS_STATUS:   w = {27'h0000000, status_word};
            OFS_IRQ_STAT: w = {27'h0000000, irq_stat_r};
            OFS_IRQ_MASK: w = {27'h0000000, irq_mask_r};
            default:      w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    assign hold_len = hold_cycles(overrange_hold_select);

    // foreground calibration stops conversion, so no sample counts then
    // core swapping for background calibration is upstream; stream stays continuous
    assign take = sample_valid_i && !cal_foreground_i;

    // per-channel view of the packed word, channel A in the low bits
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            chan_smp[c] = sample_in_i[c*SAMPLE_W +: SAMPLE_W];
            chan_mag[c] = mag_top(chan_smp[c]);
        end
    end

    // one threshold for every channel; the compare adds no register stage
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            hit[c] = take && overrange_detect_enable &&
                     (chan_mag[c] >= overrange_threshold_r);
        end
    end

    // mark pin is asynchronous: three stages, accept when last two agree
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            mark_sync_r <= 3'h0;
        end else begin
            mark_sync_r <= {mark_sync_r[1:0], mark_input_pair_i};
        end
    end

    // a level not yet settled across two stages is ignored
    assign mark_agree = (mark_sync_r[1] == mark_sync_r[2]);

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            mark_lvl_r <= 1'b0;
        end else if (mark_agree) begin
            mark_lvl_r <= mark_sync_r[2] & mark_receiver_enable;
        end
    end

    // hold counters, restarted by every hit
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            for (int c = 0; c < NUM_CH; c++) begin
                hold_cnt_r[c] <= '0;
            end
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                hold_cnt_r[c] <= next_count(overrange_detect_enable, hit[c], hold_cnt_r[c],
                                            hold_len);
            end
        end
    end

    // flag stays high while the count runs and one cycle past zero
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            flag_r <= '0;
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (!overrange_detect_enable) begin
                    flag_r[c] <= 1'b0;
                end else if (hit[c]) begin
                    flag_r[c] <= 1'b1;
                end else if (hold_cnt_r[c] == '0) begin
                    flag_r[c] <= 1'b0;
                end
            end
        end
    end

    // one pin per channel, A in bit 0
    assign over_range_out_a_o = flag_r[0];
    assign over_range_out_b_o = flag_r[1];
    assign over_range_out_c_o = flag_r[2];
    assign over_range_out_d_o = flag_r[3];

    // mark is treated as a 1-bit channel registered with the samples
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            link_valid_o <= 1'b0;
        end else begin
            link_valid_o <= take;
        end
    end

    // words hold between takes; only link_valid_o marks a new one
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            link_sample_o <= '0;
        end else if (take) begin
            for (int c = 0; c < NUM_CH; c++) begin
                link_sample_o[c*SAMPLE_W +: SAMPLE_W] <=
                    mark_insert_enable ?
                    insert_mark(chan_smp[c], mark_lvl_r) :
                    chan_smp[c];
            end
        end
    end

    // previous mark level, for the rising-edge interrupt
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            mark_prev_r <= 1'b0;
        end else begin
            mark_prev_r <= mark_lvl_r;
        end
    end

    // echo only in mark mode, one cycle behind the retimed level
    assign echo_sel_ok = trigger_echo_enable && (trigger_echo_select == ECHO_SEL_MARK);

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            trigger_echo_pair_o <= 1'b0;
        end else begin
            trigger_echo_pair_o <= echo_sel_ok && mark_lvl_r;
        end
    end

    // AHB-Lite slave: zero wait, OKAY, writes land in data phase
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    // address-phase qualifiers; a stalled bus holds every phase
    assign addr_ok = hready_i && hsel_i && htrans_i[1];
    assign rd_req  = addr_ok && !hwrite_i;
    assign wr_req  = addr_ok && hwrite_i;

    // write data arrives a cycle after its address, so the address waits
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            wr_pend_r <= 1'b0;
        end else if (hready_i) begin
            wr_pend_r <= wr_req;
        end
    end

    // address kept only for writes
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            wr_addr_r <= 8'h00;
        end else if (wr_req) begin
            wr_addr_r <= haddr_i;
        end
    end

    // data-phase strobes decoded once from the latched address
    assign wr_ctrl   = wr_pend_r && (wr_addr_r == OFS_CTRL);
    assign wr_thresh = wr_pend_r && (wr_addr_r == OFS_THRESH);
    assign wr_mask   = wr_pend_r && (wr_addr_r == OFS_IRQ_MASK);
    assign wr_clear  = wr_pend_r && (wr_addr_r == OFS_IRQ_STAT);

    // status shows live flags and the retimed mark level
    assign status_word = {mark_lvl_r, flag_r};

    // read data is taken in the address phase and stands in the data phase
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (rd_req) begin
            hrdata_o <= read_word(haddr_i);
        end
    end

    // control fields take effect the cycle after the data phase
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ctrl_r <= 9'h000;
        end else if (wr_ctrl) begin
            ctrl_r <= hwdata_i[8:0];
        end
    end

    // shared threshold, reset near the top of the 8-bit magnitude scale
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            overrange_threshold_r <= THRESH_RESET;
        end else if (wr_thresh) begin
            overrange_threshold_r <= hwdata_i[7:0];
        end
    end

    // mask has the status layout
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            irq_mask_r <= 5'h00;
        end else if (wr_mask) begin
            irq_mask_r <= hwdata_i[4:0];
        end
    end

    assign mark_rise  = mark_lvl_r & ~mark_prev_r;
    // write-one-to-clear bits of the current data phase
    assign clear_mask = wr_clear ? hwdata_i[4:0] : 5'h00;

    // sticky events; a set in the clearing cycle wins
    assign irq_set = {mark_rise, hit};

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            irq_stat_r <= 5'h00;
        end else begin
            irq_stat_r <= irq_set | (irq_stat_r & ~clear_mask);
        end
    end

    // level output, no edge memory beyond the sticky status
    assign irq_o = |(irq_stat_r & irq_mask_r);
endmodule
`default_nettype wire

/* aort_checker.sv */
// Purpose: port-level checks for aort_core
// Assumes: one clock, synchronous reset
// Notes:   hold select is a register, so only the shortest pulse is checked
`default_nettype none
module aort_checker
    import aort_pkg::*;
(
    input wire logic                       clk_sys_i,
    input wire logic                       rst_i,
    input wire logic [NUM_CH*SAMPLE_W-1:0] sample_in_i,
    input wire logic                       sample_valid_i,
    input wire logic                       cal_foreground_i,
    input wire logic                       mark_input_pair_i,
    input wire logic [NUM_CH*SAMPLE_W-1:0] link_sample_o,
    input wire logic                       link_valid_o,
    input wire logic                       over_range_out_a_o,
    input wire logic                       over_range_out_b_o,
    input wire logic                       trigger_echo_pair_o,
    input wire logic                       hreadyout_o,
    input wire logic                       hresp_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    wire take = sample_valid_i && !cal_foreground_i;
    property p_take; take |=> link_valid_o; endproperty
    property p_idle; !take |=> !link_valid_o; endproperty
    property p_cal; cal_foreground_i |=> !link_valid_o; endproperty
    property p_upper;
        take |=> link_sample_o[11:1] == $past(sample_in_i[11:1])
            && link_sample_o[47:37] == $past(sample_in_i[47:37]);
    endproperty
    property p_okay; hreadyout_o && !hresp_o; endproperty
    property p_pulse; $rose(over_range_out_a_o) |-> over_range_out_a_o [*8]; endproperty
    property p_rise; $rose(over_range_out_b_o) |-> $past(take); endproperty
    property p_echo; $rose(trigger_echo_pair_o) |-> $past(mark_input_pair_i, 3); endproperty
    a_take: assert property (p_take) else $error("taken sample missing");
    a_idle: assert property (p_idle) else $error("link word without sample");
    a_cal: assert property (p_cal) else $error("output during calibration");
    a_upper: assert property (p_upper) else $error("upper sample bits wrong");
    a_okay: assert property (p_okay) else $error("bus not ready or not okay");
    a_pulse: assert property (p_pulse) else $error("flag pulse too short");
    a_rise: assert property (p_rise) else $error("flag rose without sample");
    a_echo: assert property (p_echo) else $error("echo ahead of mark");
    c_flag: cover property ($rose(over_range_out_a_o));
    c_echo: cover property ($rose(trigger_echo_pair_o));
    c_cal: cover property (cal_foreground_i && sample_valid_i);
endmodule
`default_nettype wire

/* aort_link_rx_model.sv */
// Purpose: far-side receiver: drives the mark input, counts link words
// Assumes: mark request from the bench
// Notes:   mark edges land off the clock edge on purpose
`default_nettype none
module aort_link_rx_model (
    input  wire logic        clk_sys_i,
    input  wire logic        mark_req_i,
    input  wire logic        link_valid_i,
    output logic             mark_o,
    output logic [31:0]      words_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial mark_o = 1'b0;
    initial words_o = 32'h0;
    // skew unrelated to the clock phase
    always @(mark_req_i) mark_o <= #17 mark_req_i;
    always @(posedge clk_sys_i) if (link_valid_i) words_o <= words_o + 32'h1;
endmodule
`default_nettype wire

/* test_adc_overrange_and_timestamp.sv */
// Purpose: random and corner stimulus for aort_core
// Assumes: zero wait bus; mark skewed by the far-side model
// Notes:   flag model keeps one hold count per channel
`default_nettype none
module test_adc_overrange_and_timestamp
    import aort_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 0, rst_i = 1, sv = 0, cal = 0, mreq = 0, hw = 0, e_lv = 0;
    logic mark, lv, echo, irq, hro, hrs;
    logic [47:0] smp = 0, lnk, e_lnk;
    logic [31:0] hwd = 0, hrd, rd, words, tk = 0;
    logic [7:0] ha = 0;
    logic [1:0] ht = 0;
    logic [3:0] fl, e_fl = 0;
    int seed = 97205, bad_count = 0, checked = 0, cnt[4];
    always #25 clk_sys_i = ~clk_sys_i;
    aort_core aort_core_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .sample_in_i(smp),
        .sample_valid_i(sv), .cal_foreground_i(cal), .mark_input_pair_i(mark),
        .link_sample_o(lnk), .link_valid_o(lv), .over_range_out_a_o(fl[0]),
        .over_range_out_b_o(fl[1]), .over_range_out_c_o(fl[2]), .over_range_out_d_o(fl[3]),
        .trigger_echo_pair_o(echo), .irq_o(irq), .hsel_i(1'b1), .haddr_i(ha), .htrans_i(ht),
        .hwrite_i(hw), .hsize_i(3'h2), .hwdata_i(hwd), .hready_i(hro), .hrdata_o(hrd),
        .hreadyout_o(hro), .hresp_o(hrs));
    aort_link_rx_model aort_link_rx_model_i (.clk_sys_i(clk_sys_i), .mark_req_i(mreq),
        .link_valid_i(lv), .mark_o(mark), .words_o(words));
    task chk_val(input logic [47:0] g, input logic [47:0] e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("Error %0t value %h expected %h", $time, g, e);
        end
    endtask
    task chk_flag(input logic g, input logic e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("Error %0t flag %b expected %b", $time, g, e);
        end
    endtask
    task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        ha <= a;
        hw <= w;
        ht <= 2'h2;
        do @(posedge clk_sys_i); while (hro !== 1'b1);
        ht <= 2'h0;
        hwd <= d;
        do @(posedge clk_sys_i); while (hro !== 1'b1);
        rd = hrd;
    endtask
    function logic [7:0] mag8(input logic [11:0] s);
        logic [11:0] m;
        m = (s == SAMPLE_MOST_NEG) ? {1'b0, MAG_SAT} : (s[11] ? -s : s);
        return m[10:3];
    endfunction
    task run(input logic [8:0] ctl, input logic [7:0] th, input logic mk);
        int i, c, l;
        logic [11:0] s, r;
        l = 8 << ctl[3:1];
        bus(OFS_THRESH, 1'b1, {24'h0, th});
        bus(OFS_CTRL, 1'b1, {23'h0, ctl});
        mreq <= mk;
        repeat (12) @(posedge clk_sys_i);
        cnt = '{default: 0};
        for (i = 0; i < 3000; i++) begin
            @(posedge clk_sys_i);
            chk_flag(lv, e_lv);
            if (e_lv) chk_val(lnk, e_lnk);
            chk_val({44'h0, fl}, {44'h0, e_fl});
            e_lv = sv && !cal;
            tk += {31'h0, e_lv};
            for (c = 0; c < 4; c++) begin
                s = smp[c*12+:12];
                e_lnk[c*12+:12] = ctl[8] ? {s[11:1], mk} : s;
                if (!ctl[0]) cnt[c] = 0;
                else if (e_lv && mag8(s) >= th) cnt[c] = l;
                else if (cnt[c] > 0) cnt[c]--;
                e_fl[c] = cnt[c] != 0;
                r = $random(seed);
                if (r[3:0] == 4'h0) r = r[4] ? SAMPLE_MOST_NEG : 12'h7FF;
                smp[c*12+:12] <= r;
            end
            sv <= (i < 1900) && $random(seed) % 2 != 0;
            cal <= $random(seed) % 8 == 0;
        end
        $display("phase with control %h done", ctl);
    endtask
    task complete_run;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #2000000;
        bad_count++;
        complete_run;
    end
    initial begin
        repeat (12) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        bus(OFS_CTRL, 1'b0, 0); chk_val({16'h0, rd}, 48'h0);
        bus(OFS_THRESH, 1'b0, 0); chk_val({16'h0, rd}, {40'h0, THRESH_RESET});
        bus(8'h14, 1'b1, 32'hFFFF); bus(8'h14, 1'b0, 0); chk_val({16'h0, rd}, 48'h0);
        $display("register reset test done");
        run(9'h001, 8'hF0, 1'b0);
        run(9'h185, 8'hFF, 1'b1);
        run(9'h00E, 8'h00, 1'b0);
        run(9'h18F, 8'hE0, 1'b1);
        chk_val({16'h0, words}, {16'h0, tk});
        mreq <= 1'b0;
        bus(OFS_IRQ_MASK, 1'b1, 0);
        bus(OFS_CTRL, 1'b1, 32'hF0);
        bus(OFS_IRQ_STAT, 1'b1, 32'h1F);
        mreq <= 1'b1;
        repeat (10) @(posedge clk_sys_i);
        chk_flag(echo, 1'b1);
        chk_flag(irq, 1'b0);
        bus(OFS_STATUS, 1'b0, 0); chk_flag(rd[4], 1'b1);
        bus(OFS_IRQ_MASK, 1'b1, 32'h10); @(posedge clk_sys_i); chk_flag(irq, 1'b1);
        bus(OFS_IRQ_STAT, 1'b1, 32'h10); @(posedge clk_sys_i); chk_flag(irq, 1'b0);
        bus(OFS_CTRL, 1'b1, 32'hD0);
        repeat (4) @(posedge clk_sys_i);
        chk_flag(echo, 1'b0);
        $display("mark echo and interrupt test done");
        complete_run;
    end
endmodule
bind aort_core aort_checker aort_checker_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .sample_in_i(sample_in_i), .sample_valid_i(sample_valid_i),
    .cal_foreground_i(cal_foreground_i), .mark_input_pair_i(mark_input_pair_i),
    .link_sample_o(link_sample_o), .link_valid_o(link_valid_o),
    .over_range_out_a_o(over_range_out_a_o), .over_range_out_b_o(over_range_out_b_o),
    .trigger_echo_pair_o(trigger_echo_pair_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o));
`default_nettype wire
